// ===== src/csrb_top.v
// register bank of the clock synthesizer with staged divider and reset controls
`include "csrb_defines.vh"
module csrb_top #(
  parameter NSTAT = 8
) (
  input  wire              mclk_i,
  input  wire              soft_reset_bit_i,
  input  wire              ce_i,
  input  wire              wr_i,
  input  wire              rd_i,
  input  wire [6:0]        addr_i,
  input  wire [7:0]        wdata_i,
  input  wire              rom_bank_select_i,
  input  wire [1:0]        if_pins_i,
  input  wire              test_pin_i,
  input  wire [2:0]        ac_pins_i,
  input  wire              autocfg_done_i,
  input  wire [NSTAT-1:0]  rt_status_i,
  input  wire [41:0]       fb_live_i,
  input  wire              so_data_i,
  input  wire              so_active_i,
  input  wire [7:0]        ee_rdata_i,
  output reg  [7:0]        rdata_o,
  output reg               ee_sel_o,
  output reg               ee_wr_o,
  output reg               ee_rd_o,
  output reg               so_out_o,
  output reg               so_oe_o,
  output reg               core_rst_o,
  output reg               autocfg_start_o,
  output reg               irq_o,
  output reg  [9:0]        out_stop_o,
  output reg               ring_osc_pd_o,
  output reg               doubler_en_o,
  output reg               xtal_drv_en_o,
  output reg               xa_ext_en_o,
  output reg               pll_en_o,
  output reg  [2:0]        input_en_o,
  output reg  [9:0]        out_en_o,
  output reg  [11:0]       group_src_o,
  output reg  [5:0]        group_on_o,
  output reg  [41:0]       fb_div_o
);
  // configuration state
  reg        bank_reg;
  reg [1:0]  master_config_one_hi_reg;
  reg [5:0]  master_config_one_lo_reg;
  // reset bits and the rest of the master register live in separate processes
  wire [7:0] master_config_one_reg = {master_config_one_hi_reg, master_config_one_lo_reg};
  reg [7:0]  master_config_two_reg;
  reg [7:0]  pllen_reg;
  reg [7:0]  icen_reg;
  reg [7:0]  output_enable_low_reg;
  reg [7:0]  output_enable_high_reg;
  reg [7:0]  mux1_reg;
  reg [7:0]  mux2_reg;
  reg [7:0]  stop1_reg;
  reg [7:0]  stop2_reg;
  reg [9:0]  src_glob_reg;
  reg [6:0]  busaddr_reg;
  reg        cfgd_reg;
  reg [5:0]  cfgpin_reg;
  reg [7:0]  ie_reg;
  reg [7:0]  rise_en_reg;
  reg        rdlive_reg;
  reg [39:0] xfer_reg;
  reg [41:0] fb_reg;
  reg        hard_reset_bit_d_reg;
  wire [NSTAT-1:0] lat_w;
  localparam [7:0] MASTER_CONFIG_ONE_RST = `CSRB_RST_MASTER_CONFIG_ONE;

  // 2-bit group source code is legal unless it is the unused value
  function mux_live;
    input [1:0] code;
    begin
      mux_live = (code != `CSRB_MUX_NONE);
    end
  endfunction

  // address decode: bank select visible always, ROM bank wins over EEPROM
  wire bank_ee   = bank_reg && !rom_bank_select_i;
  wire to_ee     = bank_ee && (addr_i != `CSRB_A_BANK);
  wire reg_wr    = ce_i && wr_i && !to_ee;
  wire reg_rd    = ce_i && rd_i && !to_ee;
  wire soft_rst  = master_config_one_reg[`CSRB_B_SOFT_RESET_BIT];
  wire hard_rst  = master_config_one_reg[`CSRB_B_HARD_RESET_BIT];
  wire core_rst  = soft_reset_bit_i || soft_rst || hard_rst;
  wire full_rst  = soft_reset_bit_i || hard_rst;
  wire lat_clr   = reg_wr && (addr_i == `CSRB_A_LATST);
  wire [2:0] fb_idx = addr_i[2:0] - 3'd1;
  wire fb_addr   = (addr_i >= `CSRB_A_FB1) && (addr_i <= `CSRB_A_FB6);

  // latched status bits, all set on a rising edge since rise_en_reg is never written and stays all ones
  genvar gi;
  generate
    for (gi = 0; gi < NSTAT; gi = gi + 1) begin : g_lat
      csrb_latch_bit csrb_latch_bit_inst (
        .mclk_i    (mclk_i),
        .soft_reset_bit_i    (core_rst),
        .ce_i      (ce_i),
        .sig_i     (rt_status_i[gi]),
        .rise_en_i (rise_en_reg[gi]),
        .fall_en_i (!rise_en_reg[gi]),
        .clr_i     (lat_clr && wdata_i[gi]),
        .flag_o    (lat_w[gi])
      );
    end
  endgenerate

  // soft and hard reset bits: spared by soft/hard reset, cleared only by the pin
  always @(posedge mclk_i) begin
    if (soft_reset_bit_i) begin
      master_config_one_hi_reg   <= MASTER_CONFIG_ONE_RST[7:6];
      bank_reg      <= 1'b0;
    end else if (ce_i) begin
      if (reg_wr && addr_i == `CSRB_A_MASTER_CONFIG_ONE) begin
        master_config_one_hi_reg <= wdata_i[7:6];
      end
      if (ce_i && wr_i && addr_i == `CSRB_A_BANK) begin
        bank_reg <= wdata_i[`CSRB_B_BANK];
      end
    end
  end

  // bus address: pin reset only, low bits from interface pins
  always @(posedge mclk_i) begin
    if (soft_reset_bit_i) begin
      busaddr_reg <= {`CSRB_RST_BUSHI, if_pins_i};
    end else if (ce_i) begin
      if (reg_wr && addr_i == `CSRB_A_BUSADDR) begin
        busaddr_reg <= wdata_i[6:0];
      end
    end
  end

  // pin straps latched on the clock after reset pin or hard reset releases
  always @(posedge mclk_i) begin
    if (soft_reset_bit_i) begin
      cfgpin_reg <= 6'h00;
      hard_reset_bit_d_reg <= 1'b1;
    end else if (ce_i) begin
      hard_reset_bit_d_reg <= hard_rst;
      if (hard_reset_bit_d_reg && !hard_rst) begin
        cfgpin_reg <= {if_pins_i, test_pin_i, ac_pins_i};
      end
    end
  end

  // configuration fields revert to defaults under any reset
  always @(posedge mclk_i) begin
    if (core_rst) begin
      master_config_one_lo_reg   <= MASTER_CONFIG_ONE_RST[5:0];
      master_config_two_reg      <= `CSRB_RST_MASTER_CONFIG_TWO;
      pllen_reg     <= `CSRB_RST_PLLEN;
      icen_reg      <= `CSRB_RST_ICEN;
      output_enable_low_reg     <= `CSRB_RST_OCEN;
      output_enable_high_reg     <= `CSRB_RST_OCEN;
      mux1_reg      <= `CSRB_RST_MUX;
      mux2_reg      <= `CSRB_RST_MUX;
      stop1_reg     <= `CSRB_RST_STOP;
      stop2_reg     <= `CSRB_RST_STOP;
      src_glob_reg  <= {10{1'b1}};
      ie_reg        <= 8'h00;
      rise_en_reg   <= 8'hFF;
      rdlive_reg    <= 1'b0;
      xfer_reg      <= 40'h00_0000_0000;
      fb_reg        <= `CSRB_RST_FB;
      cfgd_reg      <= 1'b0;
    end else if (ce_i && reg_wr) begin
      cfgd_reg <= 1'b1; // set by any register write
      case (addr_i)
        `CSRB_A_MASTER_CONFIG_ONE:  master_config_one_lo_reg <= wdata_i[5:0];
        `CSRB_A_MASTER_CONFIG_TWO:  master_config_two_reg <= wdata_i;
        `CSRB_A_PLLEN: pllen_reg <= wdata_i;
        `CSRB_A_ICEN:  icen_reg <= wdata_i;
        `CSRB_A_OUTPUT_ENABLE_LOW: output_enable_low_reg <= wdata_i;
        `CSRB_A_OUTPUT_ENABLE_HIGH: output_enable_high_reg <= wdata_i;
        `CSRB_A_MUX1:  mux1_reg <= wdata_i;
        `CSRB_A_MUX2:  mux2_reg <= wdata_i;
        `CSRB_A_STOP1: stop1_reg <= wdata_i;
        `CSRB_A_STOP2: stop2_reg <= wdata_i;
        // bit n: output n uses the global stop (stop source 0001)
        `CSRB_A_SRC:   src_glob_reg <= {src_glob_reg[9:8], wdata_i};
        `CSRB_A_IE:    ie_reg <= wdata_i;
        `CSRB_A_FBCTL: begin
          rdlive_reg  <= wdata_i[`CSRB_B_RDLIVE];
          rise_en_reg <= rise_en_reg;
        end
        `CSRB_A_FB6:   fb_reg <= {wdata_i[1:0], xfer_reg};
        default: begin
          if (fb_addr) begin
            xfer_reg[fb_idx*8 +: 8] <= wdata_i;
          end
        end
      endcase
    end
  end

  // read mux; status and pin fields are read-only
  reg [7:0] rd_next;
  always @* begin
    rd_next = 8'h00;
    case (addr_i)
      `CSRB_A_BANK:    rd_next = {bank_reg, 7'h00};
      `CSRB_A_MASTER_CONFIG_ONE:    rd_next = master_config_one_reg;
      `CSRB_A_MASTER_CONFIG_TWO:    rd_next = master_config_two_reg;
      `CSRB_A_PLLEN:   rd_next = pllen_reg;
      `CSRB_A_ICEN:    rd_next = icen_reg;
      `CSRB_A_OUTPUT_ENABLE_LOW:   rd_next = output_enable_low_reg;
      `CSRB_A_OUTPUT_ENABLE_HIGH:   rd_next = output_enable_high_reg;
      `CSRB_A_MUX1:    rd_next = mux1_reg;
      `CSRB_A_MUX2:    rd_next = mux2_reg;
      `CSRB_A_STOP1:   rd_next = stop1_reg;
      `CSRB_A_STOP2:   rd_next = stop2_reg;
      `CSRB_A_SRC:     rd_next = src_glob_reg[7:0];
      `CSRB_A_BUSADDR: rd_next = {1'b0, busaddr_reg};
      `CSRB_A_CONFIGURATION_STATUS:   rd_next = {cfgd_reg, 1'b0, cfgpin_reg};
      `CSRB_A_LATST:   rd_next = lat_w;
      `CSRB_A_RTST:    rd_next = rt_status_i;
      `CSRB_A_IE:      rd_next = ie_reg;
      `CSRB_A_FBCTL:   rd_next = {7'h00, rdlive_reg};
      default: begin
        if (fb_addr) begin
          // top byte holds only bits 41:40; byte index would run past the field
          if (addr_i == `CSRB_A_FB6) begin
            if (rdlive_reg) begin
              rd_next = {6'h00, fb_live_i[41:40]};
            end else begin
              rd_next = {6'h00, fb_reg[41:40]};
            end
          end else if (rdlive_reg) begin
            rd_next = fb_live_i[fb_idx*8 +: 8];
          end else begin
            rd_next = fb_reg[fb_idx*8 +: 8];
          end
        end
      end
    endcase
  end

  // registered outputs
  always @(posedge mclk_i) begin
    if (soft_reset_bit_i) begin
      rdata_o         <= 8'h00;
      ee_sel_o        <= 1'b0;
      ee_wr_o         <= 1'b0;
      ee_rd_o         <= 1'b0;
      so_out_o        <= 1'b1;
      so_oe_o         <= 1'b0;
      core_rst_o      <= 1'b1;
      autocfg_start_o <= 1'b0;
      irq_o           <= 1'b0;
      out_stop_o      <= 10'h000;
      ring_osc_pd_o   <= 1'b0;
      doubler_en_o    <= 1'b0;
      xtal_drv_en_o   <= 1'b0;
      xa_ext_en_o     <= 1'b0;
      pll_en_o        <= 1'b0;
      input_en_o      <= 3'h0;
      out_en_o        <= 10'h000;
      group_src_o     <= 12'h000;
      group_on_o      <= 6'h00;
      fb_div_o        <= `CSRB_RST_FB;
    end else if (ce_i) begin
      if (rd_i) begin
        rdata_o <= reg_rd ? rd_next : ee_rdata_i;
      end
      ee_sel_o        <= bank_ee;
      ee_wr_o         <= wr_i && to_ee;
      ee_rd_o         <= rd_i && to_ee;
      // open drain drives only low
      if (master_config_one_reg[`CSRB_B_ODSO]) begin
        so_out_o <= 1'b0;
        so_oe_o  <= so_active_i && !so_data_i;
      end else begin
        so_out_o <= so_data_i;
        so_oe_o  <= so_active_i;
      end
      core_rst_o      <= core_rst;
      autocfg_start_o <= hard_reset_bit_d_reg && !hard_rst;
      irq_o           <= |(lat_w & ie_reg);
      out_stop_o      <= ({stop2_reg[1:0], stop1_reg}) |
                         ({10{master_config_one_reg[`CSRB_B_STOP]}} & src_glob_reg);
      ring_osc_pd_o   <= master_config_one_reg[`CSRB_B_RING_OSC_DISABLE] && autocfg_done_i;
      doubler_en_o    <= master_config_two_reg[`CSRB_B_DBL];
      xtal_drv_en_o   <= (master_config_two_reg[1:0] == 2'b01);
      xa_ext_en_o     <= (master_config_two_reg[1:0] == 2'b10);
      pll_en_o        <= pllen_reg[0];
      input_en_o      <= icen_reg[2:0];
      out_en_o        <= {output_enable_high_reg[1:0], output_enable_low_reg};
      group_src_o     <= {mux2_reg[5:0], mux1_reg[5:0]};
      group_on_o      <= {mux_live(mux2_reg[5:4]), mux_live(mux2_reg[3:2]),
                          mux_live(mux2_reg[1:0]), mux_live(mux1_reg[5:4]),
                          mux_live(mux1_reg[3:2]), mux_live(mux1_reg[1:0])};
      fb_div_o        <= fb_reg;
    end
  end
endmodule

// ===== src/csrb_defines.vh
// register offsets, field positions and reset values of the clock synth register bank
// Functional notes
// - read-only fields ignore writes; other fields read and write.
// - real-time status bits read the live monitored level.
// - latched status sets on its edge, clears on write of one only.
// - latched status with its enable set raises an interrupt request.
// - reset returns every configuration field to its default.
// - lower bytes go to a transfer register; highest byte commits all.
// - without highest byte write the active field stays unchanged.
// - read-live control makes divider reads return live value, transfer untouched.
// - ROM bank select beats EEPROM bank select in address mapping.
// - soft reset spares interface, itself, hard reset, bus address, config status 5:0.
// - hard reset acts like reset pin, latches pin defaults, starts auto-configuration; code clears only what soft reset clears, bus address kept.
// - output stop is global stop OR own stop when stop source is 0001.
// - ring oscillator disable: 0 enabled, 1 powered down, after auto-configuration.
// - open-drain serial out drives low only; otherwise drives both levels.
// - crystal pin mode 00 off, 01 crystal, 10 external oscillator, 11 unused.
// - enable bits power the PLL and each of three input receivers.
// - per-output enable bit powers that output's divider, phase and stop logic.
// - group source 00 integer, 01 fractional or bypass, 11 fanout, 10 unused.
`ifndef CSRB_DEFINES_VH
`define CSRB_DEFINES_VH
`define CSRB_A_BANK      7'h00
`define CSRB_A_MASTER_CONFIG_ONE      7'h01
`define CSRB_A_MASTER_CONFIG_TWO      7'h02
`define CSRB_A_PLLEN     7'h03
`define CSRB_A_ICEN      7'h04
`define CSRB_A_OUTPUT_ENABLE_LOW     7'h05
`define CSRB_A_OUTPUT_ENABLE_HIGH     7'h06
`define CSRB_A_MUX1      7'h07
`define CSRB_A_MUX2      7'h08
`define CSRB_A_STOP1     7'h09
`define CSRB_A_STOP2     7'h0A
`define CSRB_A_SRC       7'h0B
`define CSRB_A_BUSADDR   7'h0C
`define CSRB_A_CONFIGURATION_STATUS     7'h40
`define CSRB_A_LATST     7'h41
`define CSRB_A_RTST      7'h42
`define CSRB_A_IE        7'h43
`define CSRB_A_FBCTL     7'h50
`define CSRB_A_FB1       7'h51
`define CSRB_A_FB6       7'h56
`define CSRB_B_BANK      7
`define CSRB_B_SOFT_RESET_BIT      7
`define CSRB_B_HARD_RESET_BIT      6
`define CSRB_B_STOP      5
`define CSRB_B_RING_OSC_DISABLE     3
`define CSRB_B_ODSO      1
`define CSRB_B_DBL       2
`define CSRB_B_CFGD      7
`define CSRB_B_RDLIVE    0
`define CSRB_RST_MASTER_CONFIG_ONE    8'h00
`define CSRB_RST_MASTER_CONFIG_TWO    8'h00
`define CSRB_RST_PLLEN   8'h00
`define CSRB_RST_ICEN    8'h00
`define CSRB_RST_OCEN    8'h00
`define CSRB_RST_MUX     8'h00
`define CSRB_RST_STOP    8'h00
`define CSRB_RST_SRC     4'h1
`define CSRB_RST_BUSHI   5'h1C
`define CSRB_RST_FB      42'h000_0000_0000
`define CSRB_SRC_GLOBAL  4'h1
`define CSRB_MUX_INT     2'h0
`define CSRB_MUX_FRAC    2'h1
`define CSRB_MUX_NONE    2'h2
`define CSRB_MUX_FAN     2'h3
`endif

// ===== src/csrb_latch_bit.v
// one latched status bit with edge select and write-one-to-clear
module csrb_latch_bit (
  input  wire       mclk_i,
  input  wire       soft_reset_bit_i,
  input  wire       ce_i,
  input  wire       sig_i,
  input  wire       rise_en_i,
  input  wire       fall_en_i,
  input  wire       clr_i,
  output reg        flag_o
);
  reg sig_d_reg;

  // edge capture; a set in the clear cycle wins
  always @(posedge mclk_i) begin
    if (soft_reset_bit_i) begin
      // start from the live level so a high status leaving reset is not an edge
      sig_d_reg <= sig_i;
      flag_o    <= 1'b0;
    end else if (ce_i) begin
      sig_d_reg <= sig_i;
      if ((rise_en_i && sig_i && !sig_d_reg) || (fall_en_i && !sig_i && sig_d_reg)) begin
        flag_o <= 1'b1;
      end else if (clr_i) begin
        flag_o <= 1'b0;
      end
    end
  end
endmodule

// ===== sim/csrb_host.sv
// host model issuing one-cycle register access strobes
module csrb_host (
  input  logic       mclk_i,
  input  logic [7:0] rdata_i,
  output logic       wr_o,
  output logic       rd_o,
  output logic [6:0] addr_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle strobes from time zero
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 7'h00;
    wdata_o = 8'h00;
  end
  // one-cycle write; callers keep reserved bits at zero
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge mclk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // one-cycle read; data is taken once the strobe edge has landed
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge mclk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask
endmodule

// ===== sim/csrb_properties.sv
// port-level checker of the clock synth register bank
`include "csrb_defines.vh"
module csrb_properties #(
  parameter NSTAT = 8
) (
  input wire             mclk_i,
  input wire             soft_reset_bit_i,
  input wire             wr_i,
  input wire             rd_i,
  input wire [6:0]       addr_i,
  input wire [7:0]       wdata_i,
  input wire             autocfg_done_i,
  input wire [NSTAT-1:0] rt_status_i,
  input wire             so_active_i,
  input wire [7:0]       rdata_o,
  input wire             so_oe_o,
  input wire             core_rst_o,
  input wire             autocfg_start_o,
  input wire [9:0]       out_stop_o,
  input wire             ring_osc_pd_o,
  input wire             doubler_en_o,
  input wire             xtal_drv_en_o,
  input wire             xa_ext_en_o,
  input wire [11:0]      group_src_o,
  input wire [41:0]      fb_div_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (soft_reset_bit_i);
  // writes that may legally move the divider
  wire w_fb6 = wr_i && addr_i == `CSRB_A_FB6;
  wire w_mc1 = wr_i && addr_i == `CSRB_A_MASTER_CONFIG_ONE;
  a_group_src_follow: assert property (wr_i && addr_i == `CSRB_A_MUX1
    |-> ##2 group_src_o[5:0] == $past(wdata_i[5:0], 2))
    else $error("group source does not follow its write");
  a_live_status_read: assert property (rd_i && addr_i == `CSRB_A_RTST
    |=> rdata_o == $past(rt_status_i))
    else $error("live status read is not the present level");
  a_unmapped_read_zero: assert property (rd_i && addr_i == 7'h20 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_divider_held: assert property ($changed(fb_div_o) |-> $past(w_fb6) || $past(w_fb6, 2)
    || $past(w_mc1) || $past(w_mc1, 2) || $past(core_rst_o))
    else $error("divider moved without a top byte write");
  a_own_stop_or: assert property (wr_i && addr_i == `CSRB_A_STOP1 && wdata_i == 8'hFF
    |-> ##2 out_stop_o[7:0] == 8'hFF)
    else $error("own stop bits do not stop outputs");
  a_ring_osc_gate: assert property (ring_osc_pd_o |-> $past(autocfg_done_i))
    else $error("ring oscillator down before auto-configuration");
  a_serial_idle_off: assert property (!so_active_i |=> !so_oe_o)
    else $error("serial output driven outside its window");
  a_crystal_mode: assert property (wr_i && addr_i == `CSRB_A_MASTER_CONFIG_TWO |-> ##2
    xtal_drv_en_o == ($past(wdata_i[1:0], 2) == 2'h1)
    && xa_ext_en_o == ($past(wdata_i[1:0], 2) == 2'h2)
    && doubler_en_o == $past(wdata_i[2], 2))
    else $error("crystal mode outputs wrong");
  a_start_one_cycle: assert property (autocfg_start_o |=> !autocfg_start_o)
    else $error("start pulse longer than one cycle");
endmodule
bind csrb_top csrb_properties #(.NSTAT(NSTAT)) csrb_properties_inst (.*);

// ===== sim/csrb_top_test.sv
// self-checking bench of the clock synth register bank
module csrb_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam NSTAT = 8;
  localparam XWAIT = 20; // crystal settle wait shortened to cycles
  logic             mclk_i = 1'b0;
  logic             soft_reset_bit_i = 1'b1;
  logic             ce_i = 1'b1;
  logic             rom_bank_select_i = 1'b0;
  logic             test_pin_i = 1'b0;
  logic             autocfg_done_i = 1'b0;
  logic             so_data_i = 1'b0;
  logic             so_active_i = 1'b0;
  logic [1:0]       if_pins_i = 2'h0;
  logic [2:0]       ac_pins_i = 3'h0;
  logic [7:0]       ee_rdata_i = 8'h00;
  logic [NSTAT-1:0] rt_status_i = 8'h00;
  logic [41:0]      fb_live_i = 42'h2A5_A5A5_A5A5;
  logic             wr_i, rd_i, ee_sel_o, ee_wr_o, ee_rd_o, so_out_o, so_oe_o, irq_o;
  logic             core_rst_o, autocfg_start_o, ring_osc_pd_o, doubler_en_o;
  logic             xtal_drv_en_o, xa_ext_en_o, pll_en_o;
  logic [2:0]       input_en_o;
  logic [6:0]       addr_i;
  logic [7:0]       wdata_i, rdata_o;
  logic [9:0]       out_stop_o, out_en_o;
  logic [11:0]      group_src_o;
  logic [5:0]       group_on_o;
  logic [41:0]      fb_div_o;
  int               failures = 0;
  int               n_checks = 0;
  csrb_top #(.NSTAT(NSTAT)) csrb_top_inst (.*);
  csrb_host csrb_host_inst (
    .mclk_i  (mclk_i),
    .rdata_i (rdata_o),
    .wr_o    (wr_i),
    .rd_o    (rd_i),
    .addr_o  (addr_i),
    .wdata_o (wdata_i)
  );
  always #25 mclk_i = ~mclk_i;
  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic ck(input string n, input logic [41:0] e, input logic [41:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rc(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    csrb_host_inst.rd(a, d);
    n_checks++;
    if (d !== e) begin
      failures++;
      $display("unexpected rdata at %h exp %h got %h", a, e, d);
    end
  endtask
  task automatic w(input logic [6:0] a, input logic [7:0] d);
    csrb_host_inst.wr(a, d);
  endtask
  // let a write reach the derived outputs
  task automatic st();
    repeat (2) @(posedge mclk_i);
    #1;
  endtask
  task automatic t_reset();
    logic seen;
    seen = 1'b0;
    rc(7'h01, 8'h00);
    rc(7'h02, 8'h00);
    rc(7'h05, 8'h00);
    rc(7'h0C, 8'h70);
    ck("fb", 42'h0, fb_div_o);
    w(7'h0C, 8'h12);
    w(7'h05, 8'hFF);
    w(7'h01, 8'h80);
    st();
    ck("core_rst", 1'b1, core_rst_o);
    ck("out_en", 10'h000, out_en_o);
    w(7'h01, 8'h00);
    rc(7'h0C, 8'h12);
    rc(7'h05, 8'h00);
    @(posedge mclk_i);
    ac_pins_i <= 3'h5;
    w(7'h01, 8'h40);
    w(7'h01, 8'h00);
    for (int i = 0; i < 8 && !seen; i++) begin
      #1;
      seen = autocfg_start_o;
      @(posedge mclk_i);
    end
    ck("start", 1'b1, seen);
    rc(7'h40, 8'h05);
    w(7'h40, 8'hFF);
    rc(7'h40, 8'h85);
    $display("reset test done");
  endtask
  task automatic t_en();
    w(7'h03, 8'h01);
    w(7'h04, 8'h07);
    w(7'h05, 8'h5A);
    w(7'h06, 8'h03);
    st();
    ck("pll", 1'b1, pll_en_o);
    ck("inp", 3'h7, input_en_o);
    ck("oen", 10'h35A, out_en_o);
    $display("enable test done");
  endtask
  task automatic t_status();
    @(posedge mclk_i);
    rt_status_i <= 8'h05;
    st();
    rc(7'h42, 8'h05);
    w(7'h42, 8'hFF);
    rc(7'h42, 8'h05);
    rc(7'h41, 8'h05);
    w(7'h41, 8'h00);
    rc(7'h41, 8'h05);
    w(7'h41, 8'h01);
    rc(7'h41, 8'h04);
    w(7'h43, 8'h04);
    st();
    ck("irq", 1'b1, irq_o);
    w(7'h43, 8'h00);
    st();
    ck("irq", 1'b0, irq_o);
    @(posedge mclk_i);
    rt_status_i <= 8'h00;
    st();
    rc(7'h41, 8'h04);
    $display("status test done");
  endtask
  task automatic t_div();
    for (int i = 1; i < 6; i++)
      w(7'(7'h50 + i), 8'(8'h11 * i));
    st();
    ck("fb", 42'h0, fb_div_o);
    w(7'h56, 8'h03);
    st();
    ck("fb", 42'h3_5544_3322_11, fb_div_o);
    w(7'h51, 8'hEE);
    st();
    ck("fb", 42'h3_5544_3322_11, fb_div_o);
    w(7'h50, 8'h01);
    rc(7'h51, 8'hA5);
    rc(7'h56, 8'h02);
    w(7'h50, 8'h00);
    w(7'h56, 8'h03);
    st();
    ck("fb", 42'h3_5544_3322_EE, fb_div_o);
    rc(7'h56, 8'h03);
    rc(7'h51, 8'hEE);
    $display("divider test done");
  endtask
  task automatic t_mux();
    for (int c = 0; c < 4; c++) begin
      w(7'h07, 8'(c * 8'h15));
      w(7'h08, 8'(c * 8'h15));
      st();
      ck("src", {6{2'(c)}}, group_src_o);
      ck("on", (c == 2) ? 6'h00 : 6'h3F, group_on_o);
    end
    $display("mux test done");
  endtask
  task automatic t_xtal();
    for (int c = 0; c < 3; c++) begin
      w(7'h02, 8'(c));
      st();
      ck("xtal", c == 1, xtal_drv_en_o);
      ck("ext", c == 2, xa_ext_en_o);
    end
    w(7'h02, 8'h01);
    repeat (XWAIT) @(posedge mclk_i);
    w(7'h02, 8'h05);
    st();
    ck("dbl", 1'b1, doubler_en_o);
    $display("crystal test done");
  endtask
  task automatic t_master_config_one();
    w(7'h01, 8'h20);
    st();
    ck("stop", 10'h3FF, out_stop_o);
    w(7'h0B, 8'h00);
    st();
    ck("stop", 10'h300, out_stop_o);
    w(7'h01, 8'h00);
    w(7'h09, 8'hFF);
    st();
    ck("stop", 10'h0FF, out_stop_o);
    w(7'h09, 8'h00);
    w(7'h01, 8'h0A);
    @(posedge mclk_i);
    so_active_i <= 1'b1;
    so_data_i <= 1'b1;
    st();
    ck("rosc", 1'b0, ring_osc_pd_o);
    ck("so_oe", 1'b0, so_oe_o);
    @(posedge mclk_i);
    autocfg_done_i <= 1'b1;
    so_data_i <= 1'b0;
    st();
    ck("rosc", 1'b1, ring_osc_pd_o);
    ck("so", 2'h2, {so_oe_o, so_out_o});
    w(7'h01, 8'h00);
    @(posedge mclk_i);
    so_data_i <= 1'b1;
    st();
    ck("so", 2'h3, {so_oe_o, so_out_o});
    @(posedge mclk_i);
    so_active_i <= 1'b0;
    $display("master test done");
  endtask
  // a write with the clock enable low must leave the output enable high field frozen
  task automatic t_ce();
    @(posedge mclk_i);
    ce_i <= 1'b0;
    w(7'h06, 8'h00);
    st();
    ck("oen_frozen", 10'h35A, out_en_o);
    @(posedge mclk_i);
    ce_i <= 1'b1;
    rc(7'h06, 8'h03);
    $display("freeze test done");
  endtask
  task automatic t_bank();
    w(7'h00, 8'h80);
    @(posedge mclk_i);
    ee_rdata_i <= 8'hC3;
    rc(7'h05, 8'hC3);
    ck("ee_rd", 1'b1, ee_rd_o);
    ck("ee_sel", 1'b1, ee_sel_o);
    w(7'h05, 8'h77);
    #1;
    ck("ee_wr", 1'b1, ee_wr_o);
    rc(7'h00, 8'h80);
    @(posedge mclk_i);
    rom_bank_select_i <= 1'b1;
    rc(7'h05, 8'h5A);
    ck("ee_sel", 1'b0, ee_sel_o);
    @(posedge mclk_i);
    rom_bank_select_i <= 1'b0;
    w(7'h00, 8'h00);
    rc(7'h20, 8'h00);
    $display("bank test done");
  endtask
  initial begin
    repeat (2) @(posedge mclk_i);
    soft_reset_bit_i <= 1'b0;
    t_reset();
    t_en();
    t_status();
    t_div();
    t_mux();
    t_xtal();
    t_master_config_one();
    t_ce();
    t_bank();
    wrap_up();
  end
endmodule
